// File: bar_shadow_ingress_credit_regs.sv
// Base address shadow and ingress credit handler configuration register bank.
`timescale 1ns/1ps
module bar_shadow_ingress_credit_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire shadow_credit_pkg::cfg_req_t cfg_req,
  input wire logic eeprom_load,
  input wire logic [11:0] eeprom_addr,
  input wire logic [31:0] eeprom_data,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output shadow_credit_pkg::credit_cfg_t credit_cfg
);
  import shadow_credit_pkg::*;

  localparam int NREG = 6;
  localparam logic [31:0] WMASKS [NREG] = '{BASE_LOW_LOADMASK, TIMER_MASK, MODE_RW_MASK,
    THR_P_MASK, THR_NP_MASK, THR_CPL_MASK};

  logic [31:0] vals [NREG];
  logic [NREG-1:0] hit_wr;
  logic [NREG-1:0] hit_ld;
  logic [31:0] low_val;
  logic [31:0] high_reg;
  logic [31:0] high_next;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  credit_cfg_t cfg_reg;
  logic window_64;
  logic [31:0] rd_mux;

  // Both the header offsets and the shadow offsets reach the same storage.
  function automatic int reg_index(input logic [11:0] a);
    case (a)
      OFS_BASE_LOW, OFS_HDR_BAR0: reg_index = 0;
      OFS_PEND_TIMER: reg_index = 1;
      OFS_CREDIT_MODE: reg_index = 2;
      OFS_POSTED_THR: reg_index = 3;
      OFS_NONPOSTED_THR: reg_index = 4;
      OFS_COMPLETION_THR: reg_index = 5;
      default: reg_index = NREG;
    endcase
  endfunction : reg_index

  function automatic logic is_high(input logic [11:0] a);
    is_high = (a == OFS_BASE_HIGH) || (a == OFS_HDR_BAR1);
  endfunction : is_high

  always_comb
  begin
    for (int i = 0; i < NREG; i++)
    begin
      hit_wr[i] = cfg_req.wr && (reg_index(cfg_req.addr) == i);
      hit_ld[i] = eeprom_load && (reg_index(eeprom_addr) == i);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : gen_regs
      // The map type bits are loadable only, so software writes use the narrower mask.
      localparam logic [31:0] SW_MASK = (g == 0) ? BASE_LOW_WMASK : WMASKS[g];
      logic [31:0] raw;
      masked_word_reg #(
        .WMASK(WMASKS[g]),
        .RESET_VALUE((g == 3) ? THR_P_RESET : (g == 4) ? THR_NP_RESET :
          (g == 5) ? THR_CPL_RESET : TIMER_RESET)
      ) u_reg (
        .clk(clk),
        .reset_n(reset_n),
        .wr(hit_wr[g] && !hit_ld[g]),
        .be(cfg_req.be),
        .wdata((cfg_req.wdata & SW_MASK) | (raw & ~SW_MASK)),
        .load(hit_ld[g]),
        .load_data(eeprom_data),
        .value(raw)
      );
      assign vals[g] = raw;
    end
  endgenerate

  // Bit 0 and bit 3 are never stored, and reserved map codes fall back to 32-bit.
  always_comb
  begin
    low_val = vals[0] & BASE_LOW_WMASK;
    if (vals[0][2:1] == MAP_TYPE_64)
    begin
      low_val[2:1] = MAP_TYPE_64;
    end
    else
    begin
      low_val[2:1] = MAP_TYPE_32;
    end
  end

  assign window_64 = (low_val[2:1] == MAP_TYPE_64);

  always_comb
  begin
    high_next = high_reg;
    if (!window_64)
    begin
      high_next = 32'h00000000;
    end
    else if (eeprom_load && is_high(eeprom_addr))
    begin
      high_next = eeprom_data;
    end
    else if (cfg_req.wr && is_high(cfg_req.addr))
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (cfg_req.be[b])
        begin
          high_next[8*b +: 8] = cfg_req.wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      high_reg <= 32'h00000000;
    end
    else
    begin
      high_reg <= high_next;
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (is_high(cfg_req.addr))
    begin
      rd_mux = window_64 ? high_reg : 32'h00000000;
    end
    else
    begin
      case (reg_index(cfg_req.addr))
        0: rd_mux = low_val;
        1: rd_mux = vals[1] & TIMER_MASK;
        2: rd_mux = (vals[2] & MODE_RW_MASK) | MODE_MAX_ENABLE;
        3: rd_mux = vals[3] & THR_P_MASK;
        4: rd_mux = vals[4] & THR_NP_MASK;
        5: rd_mux = vals[5] & THR_CPL_MASK;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= cfg_req.rd;
      rdata_reg <= cfg_req.rd ? rd_mux : 32'h00000000;
    end
  end

  // Software is expected to pick the timer value for payload size and width.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfg_reg <= '0;
    end
    else
    begin
      cfg_reg.pending_timer <= vals[1][7:0];
      cfg_reg.timer_source <= vals[2][23:20];
      cfg_reg.factory_mode <= vals[2][19:16];
      cfg_reg.p_data <= vals[3][8:3];
      cfg_reg.p_hdr <= vals[3][13:9];
      cfg_reg.np_data <= vals[4][8:0];
      cfg_reg.np_hdr <= vals[4][13:9];
      cfg_reg.cpl_data <= vals[5][8:3];
      cfg_reg.cpl_hdr <= vals[5][13:9];
      cfg_reg.window_base <= {(window_64 ? high_reg : 32'h00000000), low_val[31:13], 13'h0000};
      cfg_reg.window_64 <= window_64;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  assign credit_cfg = cfg_reg;
endmodule : bar_shadow_ingress_credit_regs

// File: bar_shadow_ingress_credit_regs_tb_top.sv
// Self-checking bench for the shadow and credit register bank.
`timescale 1ns/1ps
module bar_shadow_ingress_credit_regs_tb_top;
  import shadow_credit_pkg::*;
  logic clk;
  logic reset_n = 1'b0;
  cfg_req_t req = '0;
  logic ld = 1'b0;
  logic [11:0] la = 12'h0;
  logic [31:0] ldat = 32'h0;
  logic [31:0] rdata;
  logic rvalid;
  credit_cfg_t ccfg;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed;
  logic [31:0] lo, hi, tmr, mode, pt, npt, ct, d;
  logic [11:0] adr [10] = '{12'h700, 12'h704, 12'h010, 12'h014, 12'h9F4, 12'h9FC, 12'hA00,
    12'hA04, 12'hA08, 12'h708};
  bar_shadow_ingress_credit_regs DUT (.clk(clk), .reset_n(reset_n), .cfg_req(req),
    .eeprom_load(ld), .eeprom_addr(la), .eeprom_data(ldat), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .credit_cfg(ccfg));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] mrg(logic [31:0] o, m, logic [3:0] b, logic [31:0] v);
    logic [31:0] k;
    k = m & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return (o & ~k) | (v & k);
  endfunction : mrg
  function automatic logic [31:0] mdl(logic [11:0] a);
    case (a)
      OFS_BASE_LOW, OFS_HDR_BAR0: return {lo[31:13], 10'h0, lo[2:1] == MAP_TYPE_64, 2'h0};
      OFS_BASE_HIGH, OFS_HDR_BAR1: return hi;
      OFS_PEND_TIMER: return tmr;
      OFS_CREDIT_MODE: return mode | MODE_MAX_ENABLE;
      OFS_POSTED_THR: return pt;
      OFS_NONPOSTED_THR: return npt;
      OFS_COMPLETION_THR: return ct;
      default: return 32'h0;
    endcase
  endfunction : mdl
  function automatic credit_cfg_t cmdl();
    credit_cfg_t c;
    c.pending_timer = tmr[7:0];
    c.timer_source = mode[23:20];
    c.factory_mode = mode[19:16];
    c.p_hdr = pt[13:9];
    c.p_data = pt[8:3];
    c.np_hdr = npt[13:9];
    c.np_data = npt[8:0];
    c.cpl_hdr = ct[13:9];
    c.cpl_data = ct[8:3];
    c.window_base = {hi, lo[31:13], 13'h0000};
    c.window_64 = (lo[2:1] == MAP_TYPE_64);
    return c;
  endfunction : cmdl
  // A load is applied after a software write so the load wins on the same word.
  task automatic mw(logic [11:0] a, logic [3:0] b, logic [31:0] v, bit ee);
    case (a)
      OFS_BASE_LOW, OFS_HDR_BAR0: lo = mrg(lo, ee ? BASE_LOW_LOADMASK : BASE_LOW_WMASK, b, v);
      OFS_BASE_HIGH, OFS_HDR_BAR1: hi = mrg(hi, 32'hFFFFFFFF, b, v);
      OFS_PEND_TIMER: tmr = mrg(tmr, TIMER_MASK, b, v);
      OFS_CREDIT_MODE: mode = mrg(mode, MODE_RW_MASK, b, v);
      OFS_POSTED_THR: pt = mrg(pt, THR_P_MASK, b, v);
      OFS_NONPOSTED_THR: npt = mrg(npt, THR_NP_MASK, b, v);
      OFS_COMPLETION_THR: ct = mrg(ct, THR_CPL_MASK, b, v);
      default: ;
    endcase
    if (lo[2:1] != MAP_TYPE_64) hi = 32'h0;
  endtask : mw
  task automatic go(logic w, r, logic [11:0] a, logic [3:0] b, logic [31:0] v, logic l,
    logic [11:0] ea, logic [31:0] ev);
    req = '{wr: w, rd: r, addr: a, be: b, wdata: v};
    ld = l;
    la = ea;
    ldat = ev;
    if (w) mw(a, b, v, 1'b0);
    if (l) mw(ea, 4'hF, ev, 1'b1);
    @(posedge clk);
    #1;
  endtask : go
  task automatic cmp(logic [31:0] g, logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_cfg(credit_cfg_t g, credit_cfg_t e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_cfg
  // The field copy lags one edge, so it matches the model as it stood before the read.
  task automatic rd(logic [11:0] a);
    logic [31:0] e;
    credit_cfg_t c;
    e = mdl(a);
    c = cmdl();
    go(0, 1, a, 0, 0, 0, 0, 0);
    cmp({31'h0, rvalid}, 32'h1);
    cmp(rdata, e);
    cmp_cfg(ccfg, c);
  endtask : rd
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    seed = 32'h0eb7b168;
    {lo, hi, tmr, mode} = '0;
    pt = THR_P_RESET;
    npt = THR_NP_RESET;
    ct = THR_CPL_RESET;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (adr[i]) rd(adr[i]);
    $display("test reset values done");
    repeat (60)
    begin
      d = $random(seed);
      go(1, 0, adr[$unsigned($random(seed)) % 10], d[3:0], $random(seed), 0, 0, 0);
      rd(req.addr);
    end
    $display("test random writes done");
    d = $random(seed);
    go(0, 0, 0, 0, 0, 1, 12'h700, {d[31:3], 3'h4});
    repeat (8)
    begin
      d = $random(seed);
      go(1, 0, adr[1 + 2 * d[0]], d[7:4], $random(seed), 0, 0, 0);
      rd(adr[3 - 2 * d[1]]);
    end
    go(0, 0, 0, 0, 0, 1, 12'h014, $random(seed));
    rd(12'h704);
    go(0, 0, 0, 0, 0, 1, 12'hA00, $random(seed));
    rd(12'hA00);
    go(0, 0, 0, 0, 0, 1, 12'h010, d | 32'h6);
    rd(12'h700);
    rd(12'h704);
    go(1, 0, 12'h9F4, 4'h1, 32'h00000076, 0, 0, 0);
    rd(12'h9F4);
    go(1, 0, 12'h9F4, 4'hF, d, 1, 12'h9F4, ~d);
    rd(12'h9F4);
    $display("test map type and load done");
    conclude();
  end
endmodule : bar_shadow_ingress_credit_regs_tb_top
bind bar_shadow_ingress_credit_regs bsicr_props u_props (.clk(clk), .reset_n(reset_n),
  .cfg_req(cfg_req), .eeprom_load(eeprom_load), .eeprom_addr(eeprom_addr),
  .eeprom_data(eeprom_data), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .credit_cfg(credit_cfg));

// File: bsicr_props.sv
// Checker of read timing and field layout at the bank's ports.
`timescale 1ns/1ps
module bsicr_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire shadow_credit_pkg::cfg_req_t cfg_req,
  input wire logic eeprom_load,
  input wire logic [11:0] eeprom_addr,
  input wire logic [31:0] eeprom_data,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire shadow_credit_pkg::credit_cfg_t credit_cfg
);
  import shadow_credit_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // The struct lags one cycle, so each read is compared with the copy of the same edge.
  property p_rvalid;
    cfg_req.rd |=> cfg_rvalid ##1 !cfg_rvalid || $past(cfg_req.rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
  property p_low;
    cfg_req.rd && cfg_req.addr == OFS_BASE_LOW |=> (cfg_rdata & 32'h00001FF9) == 32'h0
      && cfg_rdata[31:13] == credit_cfg.window_base[31:13];
  endproperty
  a_low: assert property (p_low) else $error("low shadow layout wrong");
  property p_map;
    cfg_req.rd && cfg_req.addr == OFS_HDR_BAR0 |=>
      cfg_rdata[2:1] == (credit_cfg.window_64 ? MAP_TYPE_64 : MAP_TYPE_32);
  endproperty
  a_map: assert property (p_map) else $error("map type wrong");
  property p_high;
    cfg_req.rd && cfg_req.addr == OFS_BASE_HIGH |=>
      cfg_rdata == (credit_cfg.window_64 ? credit_cfg.window_base[63:32] : 32'h0);
  endproperty
  a_high: assert property (p_high) else $error("high shadow wrong");
  property p_timer;
    cfg_req.rd && cfg_req.addr == OFS_PEND_TIMER |=> cfg_rdata == {24'h0, credit_cfg.pending_timer};
  endproperty
  a_timer: assert property (p_timer) else $error("timer read wrong");
  property p_mode;
    cfg_req.rd && cfg_req.addr == OFS_CREDIT_MODE |=> cfg_rdata[31:24] == 8'h0
      && cfg_rdata[15:0] == 16'h00FF && cfg_rdata[23:20] == credit_cfg.timer_source;
  endproperty
  a_mode: assert property (p_mode) else $error("mode read wrong");
  property p_post;
    cfg_req.rd && cfg_req.addr == OFS_POSTED_THR |=> cfg_rdata[31:14] == 18'h0
      && cfg_rdata[13:3] == {credit_cfg.p_hdr, credit_cfg.p_data};
  endproperty
  a_post: assert property (p_post) else $error("posted threshold wrong");
  property p_np;
    cfg_req.rd && cfg_req.addr == OFS_NONPOSTED_THR |=>
      cfg_rdata == {18'h0, credit_cfg.np_hdr, credit_cfg.np_data};
  endproperty
  a_np: assert property (p_np) else $error("non-posted threshold wrong");
endmodule : bsicr_props

// File: masked_word_reg.sv
// Byte-enabled 32-bit register with a writable-bit mask and load port.
`timescale 1ns/1ps
module masked_word_reg #(
  parameter logic [31:0] WMASK = 32'hFFFFFFFF,
  parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic load,
  input wire logic [31:0] load_data,
  output logic [31:0] value
);
  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] lane_mask;

  always_comb
  begin
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WMASK;
    value_next = value_reg;
    if (load)
    begin
      value_next = load_data & WMASK;
    end
    else if (wr)
    begin
      value_next = (value_reg & ~lane_mask) | (wdata & lane_mask);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      value_reg <= RESET_VALUE & WMASK;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule : masked_word_reg

// File: shadow_credit_pkg.sv
// Package holding offsets, field layouts, reset values and carrier types for the register bank.
// What this block does
// - Mirror header base registers into two shadows.
// - Low shadow bit 0 reads zero, read-only.
// - Map type bits 2:1: 00b 32-bit, 10b 64-bit.
// - Low shadow bit 3 reads zero, non-prefetchable.
// - Base bits 31:13 writable, bits 12:4 zero.
// - Map type 10b makes high shadow writable.
// - Otherwise high shadow reads all zeros.
// - Pending timer bits 7:0 read-write, reset 00h.
// - Timer source bits 23:20 read-write, reset 0.
// - Three VC0 threshold registers: P, NP, Cpl.
// - Posted payload 8:3, header 13:9, default 30Eh.
// - Non-posted payload 8:0, header 13:9, 140Ah.
// - Completion payload 8:3, header 13:9, 28Ch.
package shadow_credit_pkg;
  localparam logic [11:0] OFS_BASE_LOW = 12'h700;
  localparam logic [11:0] OFS_BASE_HIGH = 12'h704;
  localparam logic [11:0] OFS_HDR_BAR0 = 12'h010;
  localparam logic [11:0] OFS_HDR_BAR1 = 12'h014;
  localparam logic [11:0] OFS_PEND_TIMER = 12'h9F4;
  localparam logic [11:0] OFS_CREDIT_MODE = 12'h9FC;
  localparam logic [11:0] OFS_POSTED_THR = 12'hA00;
  localparam logic [11:0] OFS_NONPOSTED_THR = 12'hA04;
  localparam logic [11:0] OFS_COMPLETION_THR = 12'hA08;
  localparam logic [1:0] MAP_TYPE_32 = 2'h0;
  localparam logic [1:0] MAP_TYPE_64 = 2'h2;
  localparam logic [31:0] BASE_LOW_WMASK = 32'hFFFFE000;
  localparam logic [31:0] BASE_LOW_LOADMASK = 32'hFFFFE006;
  localparam logic [31:0] TIMER_MASK = 32'h000000FF;
  localparam logic [31:0] MODE_RW_MASK = 32'h00FF0000;
  localparam logic [31:0] MODE_SOURCE_MASK = 32'h00F00000;
  localparam logic [31:0] MODE_MAX_ENABLE = 32'h000000FF;
  localparam logic [31:0] THR_P_MASK = 32'h00003FF8;
  localparam logic [31:0] THR_NP_MASK = 32'h00003FFF;
  localparam logic [31:0] THR_CPL_MASK = 32'h00003FF8;
  localparam logic [31:0] TIMER_RESET = 32'h00000000;
  // The joined header and payload defaults sit above reserved bits 2:0 where those exist.
  localparam logic [31:0] THR_P_RESET = 32'h00001870;
  localparam logic [31:0] THR_NP_RESET = 32'h0000140A;
  localparam logic [31:0] THR_CPL_RESET = 32'h00001460;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [7:0] pending_timer;
    logic [3:0] timer_source;
    logic [3:0] factory_mode;
    logic [4:0] p_hdr;
    logic [5:0] p_data;
    logic [4:0] np_hdr;
    logic [8:0] np_data;
    logic [4:0] cpl_hdr;
    logic [5:0] cpl_data;
    logic [63:0] window_base;
    logic window_64;
  } credit_cfg_t;
endpackage : shadow_credit_pkg
